// ==== src/pmc_defines.svh ====
/*
 * Register offsets, field positions, reset values and timing counts of the
 * power-mode controller. Assumes a 10 MHz system clock.
 */
`ifndef PMC_DEFINES_SVH
`define PMC_DEFINES_SVH

`define PMC_ADDR_W          8
`define PMC_ADDR_CTRL       8'h00
`define PMC_ADDR_STOP_IN_IDLE       8'h04
`define PMC_ADDR_STAT       8'h08

`define PMC_SLEEP_ON_WAIT_ENABLE_BIT       4
`define PMC_XTAL_BIT        8
`define PMC_PERIPHERAL_BUS_DIVIDER_LSB       19
`define PMC_PERIPHERAL_BUS_DIVIDER_MSB       20

`define PMC_CTRL_RST        32'h0000_0000
`define PMC_STOP_IN_IDLE_RST        8'h00
`define PMC_NPERIPH         8

`define PMC_CLK_NS          100
`define PMC_OSC_START_NS    102400
`define PMC_OSC_START_CYC   ((`PMC_OSC_START_NS + `PMC_CLK_NS - 1) / `PMC_CLK_NS)
`define PMC_CNT_W           11

`define PMC_PERIPHERAL_BUS_DIVIDER_W         2
`define PMC_PBCNT_W         3

`endif

// ==== src/pmc_peripheral_bus_divider.sv ====
/*
 * Peripheral bus clock divider: emits a one-cycle enable every 1, 2, 4 or 8
 * system clocks. Assumes a synchronised active-low reset.
 */
`timescale 1ns/1ps
`include "pmc_defines.svh"

module pmc_peripheral_bus_divider
(
	input  wire logic                      clk_in,
	input  wire logic                      rstn_in,
	input  wire logic                      run_in,
	input  wire logic [`PMC_PERIPHERAL_BUS_DIVIDER_W-1:0]   div_in,
	output logic                           tick_out
);

	logic [`PMC_PBCNT_W-1:0] cnt_r;

	function automatic logic [`PMC_PBCNT_W-1:0] div_max(input logic [`PMC_PERIPHERAL_BUS_DIVIDER_W-1:0] sel);
		div_max = 3'(({1'b0, 3'h1} << sel) - 4'h1);
	endfunction

	// Counter restarts when stopped so the first tick after a restart is whole
	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
			cnt_r <= 3'h0;
		else if (!run_in || cnt_r >= div_max(div_in))
			cnt_r <= 3'h0;
		else
			cnt_r <= cnt_r + 3'h1;
	end

	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
			tick_out <= 1'b0;
		else
			tick_out <= run_in && (cnt_r >= div_max(div_in));
	end

endmodule

// ==== src/pmc_pkg.sv ====
/*
 * Types of the power-mode controller: power states and wake request bundle.
 * Assumes the defines header is compiled alongside.
 */
package pmc_pkg;

	typedef enum logic [1:0]
	{
		PMC_RUN   = 2'b00,
		PMC_IDLE  = 2'b01,
		PMC_SLEEP = 2'b10,
		PMC_START = 2'b11
	} pmc_state_type;

	typedef struct packed
	{
		logic       valid;
		logic       sleep_ok;
		logic [2:0] prio;
	} pmc_wake_type;

endpackage

// ==== src/pmc_top.sv ====
/*
 * Power-mode controller: run, Idle and Sleep sequencing, peripheral gating,
 * oscillator shutdown and start-up delay, peripheral bus clock enable.
 * Assumes CPU, interrupt controller and watchdog on the same system clock.
 */
// Chosen here: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`include "pmc_defines.svh"

// Contract
// - Wait with sleep-on-wait enable clear enters Idle.
// - Idle stops the CPU clock, keeps the system clock source running.
// - Idle stops only peripherals whose stop-in-idle bit is set.
// - Sleep halts CPU, clock source and all system-clocked peripherals.
// - Sleep wakes on higher-priority sleep-capable interrupt, reset or watchdog time-out.
// - Low-priority Sleep wake keeps CPU halted, restarts bus clock, enters Idle.
// - Idle exits on higher-priority enabled interrupt, reset or watchdog time-out.
// - Low-priority Idle interrupt keeps CPU halted in Idle.
// - Watchdog counter is not cleared on Sleep entry.
// - Fail-safe clock monitor suspended throughout Sleep.
// - Brownout reset detector stays active in Sleep.
// - Restarting a crystal or PLL source waits the start-up delay; here a wake in the first Sleep cycle restarts the source without it.
// - USB may keep the oscillator running through Sleep.
// - Peripheral bus clocked at programmable fraction of system clock always; here the divider runs only in run and Idle.
// - Divider ratios 1, 2, 4, 8 applying to the whole bus.
module pmc_top
(
	input  wire logic                        clk_in,
	input  wire logic                        rstn_in,
	input  wire logic [`PMC_ADDR_W-1:0]      reg_addr_in,
	input  wire logic [31:0]                 reg_wdata_in,
	input  wire logic                        reg_wr_in,
	input  wire logic                        reg_rd_in,
	output logic      [31:0]                 reg_rdata_out,
	input  wire logic                        wait_exec_in,
	input  wire pmc_pkg::pmc_wake_type       wake_in,
	input  wire logic [2:0]                  cpu_prio_in,
	input  wire logic                        wdt_timeout_in,
	input  wire logic                        usb_osc_hold_in,
	output logic                             cpu_clk_en_out,
	output logic                             system_clock_src_en_out,
	output logic [`PMC_NPERIPH-1:0]          periph_clk_en_out,
	output logic                             peripheral_bus_clock_tick_out,
	output logic                             fail_safe_clock_monitor_en_out,
	output logic                             bor_en_out,
	output logic                             wdt_clear_out,
	output logic [1:0]                       mode_out
);

	logic                         rst_meta_r;
	logic                         rst_sync_r;
	logic [31:0]                  ctrl_r;
	logic [`PMC_NPERIPH-1:0]      stop_in_idle_r;
	pmc_pkg::pmc_state_type       state_r;
	pmc_pkg::pmc_state_type       state_nxt;
	pmc_pkg::pmc_state_type       target_r;
	pmc_pkg::pmc_state_type       target_nxt;
	logic [`PMC_CNT_W-1:0]        start_cnt_r;
	logic [`PMC_CNT_W-1:0]        start_cnt_nxt;
	logic                         osc_off_r;
	logic                         hi_prio;
	logic                         wake_sleep_hi;
	logic                         wake_sleep_lo;
	logic                         sleep_on_wait_enable;
	logic                         xtal;

	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			rst_meta_r <= 1'b0;
			rst_sync_r <= 1'b0;
		end
		else
		begin
			rst_meta_r <= 1'b1;
			rst_sync_r <= rst_meta_r;
		end
	end

	// Register writes
	always_ff @(posedge clk_in or negedge rst_sync_r)
	begin
		if (!rst_sync_r)
		begin
			ctrl_r <= `PMC_CTRL_RST;
			stop_in_idle_r <= `PMC_STOP_IN_IDLE_RST;
		end
		else if (reg_wr_in)
		begin
			if (reg_addr_in == `PMC_ADDR_CTRL)
			begin
				ctrl_r <= 32'h0000_0000;
				ctrl_r[`PMC_SLEEP_ON_WAIT_ENABLE_BIT] <= reg_wdata_in[`PMC_SLEEP_ON_WAIT_ENABLE_BIT];
				ctrl_r[`PMC_XTAL_BIT] <= reg_wdata_in[`PMC_XTAL_BIT];
				ctrl_r[`PMC_PERIPHERAL_BUS_DIVIDER_MSB:`PMC_PERIPHERAL_BUS_DIVIDER_LSB] <=
					reg_wdata_in[`PMC_PERIPHERAL_BUS_DIVIDER_MSB:`PMC_PERIPHERAL_BUS_DIVIDER_LSB];
			end
			if (reg_addr_in == `PMC_ADDR_STOP_IN_IDLE)
				stop_in_idle_r <= reg_wdata_in[`PMC_NPERIPH-1:0];
		end
	end

	// Read data one cycle after the strobe; unmapped reads return zero
	always_ff @(posedge clk_in or negedge rst_sync_r)
	begin
		if (!rst_sync_r)
			reg_rdata_out <= 32'h0000_0000;
		else if (!reg_rd_in)
			reg_rdata_out <= 32'h0000_0000;
		else
		begin
			unique case (reg_addr_in)
				`PMC_ADDR_CTRL: reg_rdata_out <= ctrl_r;
				`PMC_ADDR_STOP_IN_IDLE: reg_rdata_out <= {24'h00_0000, stop_in_idle_r};
				`PMC_ADDR_STAT: reg_rdata_out <= {28'h000_0000, osc_off_r,
					(state_r == pmc_pkg::PMC_START), state_r};
				default:        reg_rdata_out <= 32'h0000_0000;
			endcase
		end
	end

	assign sleep_on_wait_enable = ctrl_r[`PMC_SLEEP_ON_WAIT_ENABLE_BIT];
	assign xtal  = ctrl_r[`PMC_XTAL_BIT];
	assign hi_prio = wake_in.valid && (wake_in.prio > cpu_prio_in);
	assign wake_sleep_hi = (wake_in.valid && wake_in.sleep_ok && hi_prio) || wdt_timeout_in;
	assign wake_sleep_lo = wake_in.valid && wake_in.sleep_ok && !hi_prio;

	// Power state sequencing
	always_comb
	begin
		state_nxt     = state_r;
		target_nxt    = target_r;
		start_cnt_nxt = start_cnt_r;
		unique case (state_r)
			pmc_pkg::PMC_RUN:
			begin
				if (wait_exec_in)
					state_nxt = sleep_on_wait_enable ? pmc_pkg::PMC_SLEEP : pmc_pkg::PMC_IDLE;
			end
			pmc_pkg::PMC_IDLE:
			begin
				// A low-priority interrupt leaves the state untouched
				if (hi_prio || wdt_timeout_in)
					state_nxt = pmc_pkg::PMC_RUN;
			end
			pmc_pkg::PMC_SLEEP:
			begin
				if (wake_sleep_hi || wake_sleep_lo)
				begin
					target_nxt = wake_sleep_hi ? pmc_pkg::PMC_RUN : pmc_pkg::PMC_IDLE;
					if (osc_off_r && xtal)
					begin
						state_nxt     = pmc_pkg::PMC_START;
						start_cnt_nxt = `PMC_CNT_W'(`PMC_OSC_START_CYC - 1);
					end
					else
						state_nxt = target_nxt;
				end
			end
			pmc_pkg::PMC_START:
			begin
				if (start_cnt_r == `PMC_CNT_W'(0))
					state_nxt = target_r;
				else
					start_cnt_nxt = start_cnt_r - `PMC_CNT_W'(1);
			end
		endcase
	end

	always_ff @(posedge clk_in or negedge rst_sync_r)
	begin
		if (!rst_sync_r)
		begin
			state_r     <= pmc_pkg::PMC_RUN;
			target_r    <= pmc_pkg::PMC_RUN;
			start_cnt_r <= `PMC_CNT_W'(0);
		end
		else
		begin
			state_r     <= state_nxt;
			target_r    <= target_nxt;
			start_cnt_r <= start_cnt_nxt;
		end
	end

	// Oscillator shutdown in Sleep unless USB holds it
	always_ff @(posedge clk_in or negedge rst_sync_r)
	begin
		if (!rst_sync_r)
			osc_off_r <= 1'b0;
		else if (state_r == pmc_pkg::PMC_SLEEP && !usb_osc_hold_in)
			osc_off_r <= 1'b1;
		else if (state_r != pmc_pkg::PMC_SLEEP)
			osc_off_r <= 1'b0;
	end

	// Clock gating outputs follow the next state for zero-latency wake
	always_ff @(posedge clk_in or negedge rst_sync_r)
	begin
		if (!rst_sync_r)
		begin
			cpu_clk_en_out    <= 1'b1;
			system_clock_src_en_out <= 1'b1;
			periph_clk_en_out <= {`PMC_NPERIPH{1'b1}};
			fail_safe_clock_monitor_en_out       <= 1'b1;
			mode_out          <= pmc_pkg::PMC_RUN;
		end
		else
		begin
			cpu_clk_en_out    <= (state_nxt == pmc_pkg::PMC_RUN);
			system_clock_src_en_out <= (state_nxt != pmc_pkg::PMC_SLEEP) || usb_osc_hold_in;
			unique case (state_nxt)
				pmc_pkg::PMC_RUN:   periph_clk_en_out <= {`PMC_NPERIPH{1'b1}};
				pmc_pkg::PMC_IDLE:  periph_clk_en_out <= ~stop_in_idle_r;
				default:            periph_clk_en_out <= {`PMC_NPERIPH{1'b0}};
			endcase
			fail_safe_clock_monitor_en_out <= (state_nxt == pmc_pkg::PMC_RUN) ||
				(state_nxt == pmc_pkg::PMC_IDLE);
			mode_out    <= state_nxt;
		end
	end

	// Brownout detector never disabled; watchdog never cleared by mode changes
	always_ff @(posedge clk_in or negedge rst_sync_r)
	begin
		if (!rst_sync_r)
		begin
			bor_en_out    <= 1'b1;
			wdt_clear_out <= 1'b0;
		end
		else
		begin
			bor_en_out    <= 1'b1;
			wdt_clear_out <= 1'b0;
		end
	end

	pmc_peripheral_bus_divider u_peripheral_bus_divider
	(
		.clk_in   (clk_in),
		.rstn_in  (rst_sync_r),
		.run_in   (state_r == pmc_pkg::PMC_RUN || state_r == pmc_pkg::PMC_IDLE),
		.div_in   (ctrl_r[`PMC_PERIPHERAL_BUS_DIVIDER_MSB:`PMC_PERIPHERAL_BUS_DIVIDER_LSB]),
		.tick_out (peripheral_bus_clock_tick_out)
	);

	chk_wait_idle: assert property (@(posedge clk_in) disable iff (!rst_sync_r)
		state_r == pmc_pkg::PMC_RUN && wait_exec_in && !sleep_on_wait_enable |=> state_r == pmc_pkg::PMC_IDLE)
		else $error("wait without sleep enable did not enter idle");

	chk_wait_sleep: assert property (@(posedge clk_in) disable iff (!rst_sync_r)
		state_r == pmc_pkg::PMC_RUN && wait_exec_in && sleep_on_wait_enable |=> state_r == pmc_pkg::PMC_SLEEP)
		else $error("wait with sleep enable did not enter sleep");

	chk_idle_clocks: assert property (@(posedge clk_in) disable iff (!rst_sync_r)
		state_r == pmc_pkg::PMC_IDLE |-> !cpu_clk_en_out && system_clock_src_en_out)
		else $error("idle clocking wrong");

	chk_idle_stop_in_idle: assert property (@(posedge clk_in) disable iff (!rst_sync_r)
		state_r == pmc_pkg::PMC_IDLE |-> periph_clk_en_out == ~$past(stop_in_idle_r))
		else $error("idle peripheral gating wrong");

	chk_sleep_halt: assert property (@(posedge clk_in) disable iff (!rst_sync_r)
		state_r == pmc_pkg::PMC_SLEEP |-> !cpu_clk_en_out && periph_clk_en_out == 8'h00
		&& system_clock_src_en_out == $past(usb_osc_hold_in))
		else $error("sleep did not halt clocks");

	chk_sleep_wake: assert property (@(posedge clk_in) disable iff (!rst_sync_r)
		state_r == pmc_pkg::PMC_SLEEP && wake_sleep_hi |=> cpu_clk_en_out ||
		state_r == pmc_pkg::PMC_START)
		else $error("sleep wake lost");

	chk_sleep_lowp: assert property (@(posedge clk_in) disable iff (!rst_sync_r)
		state_r == pmc_pkg::PMC_SLEEP && !wake_sleep_hi && wake_sleep_lo |=>
		!cpu_clk_en_out ##0 (state_r == pmc_pkg::PMC_IDLE || state_r == pmc_pkg::PMC_START))
		else $error("low priority sleep wake wrong");

	chk_idle_exit: assert property (@(posedge clk_in) disable iff (!rst_sync_r)
		state_r == pmc_pkg::PMC_IDLE && (hi_prio || wdt_timeout_in) |=> cpu_clk_en_out)
		else $error("idle exit latency exceeded");

	chk_idle_stay: assert property (@(posedge clk_in) disable iff (!rst_sync_r)
		state_r == pmc_pkg::PMC_IDLE && !hi_prio && !wdt_timeout_in |=>
		state_r == pmc_pkg::PMC_IDLE && !cpu_clk_en_out)
		else $error("idle left without cause");

	chk_wdt_keep: assert property (@(posedge clk_in) disable iff (!rst_sync_r)
		$rose(state_r == pmc_pkg::PMC_SLEEP) |-> !wdt_clear_out)
		else $error("watchdog cleared on sleep");

	chk_fail_safe_clock_monitor_off: assert property (@(posedge clk_in) disable iff (!rst_sync_r)
		state_r == pmc_pkg::PMC_SLEEP |-> !fail_safe_clock_monitor_en_out && bor_en_out)
		else $error("monitor or brownout state wrong in sleep");

	chk_start_delay: assert property (@(posedge clk_in) disable iff (!rst_sync_r)
		$rose(state_r == pmc_pkg::PMC_START) |-> (state_r == pmc_pkg::PMC_START)[*8])
		else $error("start-up delay cut short");

	chk_pb_tick: assert property (@(posedge clk_in) disable iff (!rst_sync_r)
		$past(rst_sync_r) && state_r == pmc_pkg::PMC_RUN && $past(state_r) == pmc_pkg::PMC_RUN &&
		ctrl_r[`PMC_PERIPHERAL_BUS_DIVIDER_MSB:`PMC_PERIPHERAL_BUS_DIVIDER_LSB] == 2'h0 && $stable(ctrl_r) |-> peripheral_bus_clock_tick_out)
		else $error("undivided bus clock missing tick");

	cov_idle_wake: cover property (@(posedge clk_in) disable iff (!rst_sync_r)
		state_r == pmc_pkg::PMC_IDLE ##1 state_r == pmc_pkg::PMC_RUN);
	cov_sleep_start: cover property (@(posedge clk_in) disable iff (!rst_sync_r)
		state_r == pmc_pkg::PMC_START ##1 state_r == pmc_pkg::PMC_RUN);
	cov_sleep_idle: cover property (@(posedge clk_in) disable iff (!rst_sync_r)
		state_r == pmc_pkg::PMC_SLEEP ##1 state_r == pmc_pkg::PMC_IDLE);

endmodule

// ==== verif/pmc_cpu_model.sv ====
/*
 * Behavioural CPU core and interrupt controller facing the power-mode controller.
 * Assumes the same system clock and reset as the block under test.
 */
`timescale 1ns/1ps

module pmc_cpu_model
(
	input  wire logic              clk_in,
	input  wire logic              rstn_in,
	input  wire logic              go_wait_in,
	input  wire logic              req_in,
	input  wire logic [2:0]        req_prio_in,
	input  wire logic              req_sleep_ok_in,
	input  wire logic              cpu_clk_en_in,
	output logic                   wait_exec_out,
	output pmc_pkg::pmc_wake_type  wake_out
);
	logic       ran_r;
	logic [2:0] junk_r;

	// Wait instruction retires one cycle after the command
	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
			wait_exec_out <= 1'b0;
		else
			wait_exec_out <= go_wait_in;
	end

	// Request stays pending until the CPU clock resumes; idle fields keep changing
	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			wake_out <= '0;
			ran_r    <= 1'b1;
			junk_r   <= 3'h0;
		end
		else
		begin
			ran_r  <= cpu_clk_en_in;
			junk_r <= junk_r + 3'h1;
			if (req_in)
				wake_out <= {1'b1, req_sleep_ok_in, req_prio_in};
			else if (!wake_out.valid || (cpu_clk_en_in && !ran_r))
				wake_out <= {1'b0, junk_r[0], ~junk_r};
		end
	end
endmodule

// ==== verif/power_mode_controller_tb.sv ====
/*
 * Self-checking bench of the power-mode controller with a CPU model.
 * Assumes the defines header and package are compiled first.
 */
`timescale 1ns/1ps
`include "pmc_defines.svh"

module power_mode_controller_tb;
	logic clk_in, rstn_in, reg_wr, reg_rd, wait_exec, wdt_to, usb_hold;
	logic go, req, req_ok, cpu_en, src_en, tick, fail_safe_clock_monitor, bor, wdt_clr;
	logic [7:0]  reg_addr, periph, stop_in_idle;
	logic [31:0] reg_wdata, rdata, rv;
	logic [2:0]  cpu_prio, req_prio, p;
	logic [1:0]  mode, div;
	pmc_pkg::pmc_wake_type wake;
	int err_total, checks_done, c, k, s;

	initial
	begin
		clk_in = 1'b0;
		forever #50 clk_in = ~clk_in;
	end

	pmc_top DUT (.clk_in(clk_in), .rstn_in(rstn_in), .reg_addr_in(reg_addr),
		.reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
		.reg_rdata_out(rdata), .wait_exec_in(wait_exec), .wake_in(wake),
		.cpu_prio_in(cpu_prio), .wdt_timeout_in(wdt_to), .usb_osc_hold_in(usb_hold),
		.cpu_clk_en_out(cpu_en), .system_clock_src_en_out(src_en), .periph_clk_en_out(periph),
		.peripheral_bus_clock_tick_out(tick), .fail_safe_clock_monitor_en_out(fail_safe_clock_monitor), .bor_en_out(bor),
		.wdt_clear_out(wdt_clr), .mode_out(mode));

	pmc_cpu_model partner (.clk_in(clk_in), .rstn_in(rstn_in), .go_wait_in(go),
		.req_in(req), .req_prio_in(req_prio), .req_sleep_ok_in(req_ok),
		.cpu_clk_en_in(cpu_en), .wait_exec_out(wait_exec), .wake_out(wake));

	function automatic int exp_ticks(input logic [1:0] d, input int span);
		return span >> d;
	endfunction

	function automatic logic [7:0] exp_periph(input logic [7:0] stop);
		return ~stop;
	endfunction

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			err_total++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic end_of_test();
		$display("mismatches %0d, comparisons %0d", err_total, checks_done);
		if (err_total == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_in);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge clk_in);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a);
		@(posedge clk_in);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge clk_in);
		reg_rd <= 1'b0;
		#1 rv = rdata;
	endtask

	// Pulse a command line, then land just after the edge after the one that takes it
	task automatic pulse_wait();
		@(posedge clk_in);
		go <= 1'b1;
		@(posedge clk_in);
		go <= 1'b0;
		@(posedge clk_in);
		#1;
	endtask

	task automatic raise(input logic [2:0] pr, input logic ok);
		@(posedge clk_in);
		req      <= 1'b1;
		req_prio <= pr;
		req_ok   <= ok;
		@(posedge clk_in);
		req <= 1'b0;
		@(posedge clk_in);
		#1;
	endtask

	task automatic pulse_wdt();
		@(posedge clk_in);
		wdt_to <= 1'b1;
		@(posedge clk_in);
		wdt_to <= 1'b0;
		#1;
	endtask

	task automatic count_ticks(input int n);
		c = 0;
		repeat (n)
		begin
			@(posedge clk_in);
			#1 if (tick === 1'b1) c++;
		end
	endtask

	task automatic wait_mode(input logic [1:0] m);
		for (int i = 0; i < 2000 && mode !== m; i++)
			@(posedge clk_in) #1;
	endtask

	initial
	begin
		repeat (20000) @(posedge clk_in);
		err_total++;
		end_of_test();
	end

	initial
	begin
		{rstn_in, reg_wr, reg_rd, go, req, req_ok, wdt_to, usb_hold} = '0;
		{reg_addr, reg_wdata, req_prio, cpu_prio} = '0;
		err_total = 0;
		checks_done = 0;
		void'($urandom(19742));
		repeat (5) @(posedge clk_in);
		rstn_in <= 1'b1;
		repeat (4) @(posedge clk_in);
		#1 chk({cpu_en, src_en, fail_safe_clock_monitor, bor, wdt_clr, mode}, 32'h0000_0078);
		chk(periph, 32'h0000_00FF);
		rd(`PMC_ADDR_CTRL);
		chk(rv, `PMC_CTRL_RST);
		rd(8'hFC);
		chk(rv, 32'h0000_0000);
		for (k = 0; k < 4; k++)
		begin
			wr(`PMC_ADDR_CTRL, k << `PMC_PERIPHERAL_BUS_DIVIDER_LSB);
			count_ticks(32);
			chk(c, exp_ticks(k, 32));
		end
		for (k = 0; k < 3; k++)
		begin
			stop_in_idle = $urandom;
			div = $urandom;
			p = 1 + $urandom % 6;
			@(posedge clk_in);
			cpu_prio <= p;
			wr(`PMC_ADDR_STOP_IN_IDLE, stop_in_idle);
			rd(`PMC_ADDR_STOP_IN_IDLE);
			chk(rv, stop_in_idle);
			wr(`PMC_ADDR_CTRL, div << `PMC_PERIPHERAL_BUS_DIVIDER_LSB);
			pulse_wait();
			chk({mode, cpu_en, src_en}, 32'h0000_0005);
			chk(periph, exp_periph(stop_in_idle));
			count_ticks(32);
			chk(c, exp_ticks(div, 32));
			rd(`PMC_ADDR_STAT);
			chk(rv[1:0], 32'h0000_0001);
			raise($urandom % (p + 1), 1'b0);
			chk({mode, cpu_en}, 32'h0000_0002);
			if (k == 2)
				pulse_wdt();
			else
				raise(p + 1 + $urandom % (7 - p), 1'b0);
			chk({mode, cpu_en}, 32'h0000_0001);
			chk(periph, 32'h0000_00FF);
		end
		for (s = 0; s < 4; s++)
		begin
			div = $urandom;
			@(posedge clk_in);
			usb_hold <= (s == 2);
			wr(`PMC_ADDR_CTRL, (1 << `PMC_SLEEP_ON_WAIT_ENABLE_BIT) | ((s == 3) << `PMC_XTAL_BIT)
				| (div << `PMC_PERIPHERAL_BUS_DIVIDER_LSB));
			pulse_wait();
			chk({mode, cpu_en, periph}, 32'h0000_0400);
			chk({fail_safe_clock_monitor, bor, wdt_clr}, 32'h0000_0002);
			chk(src_en, s == 2);
			count_ticks(16);
			chk(c, 32'h0000_0000);
			chk(wdt_clr, 32'h0000_0000);
			rd(`PMC_ADDR_STAT);
			chk(rv, {28'h000_0000, s != 2, 3'b010});
			if (s == 0)
			begin
				raise(p + 1 + $urandom % (7 - p), 1'b0);
				chk(mode, 32'h0000_0002);
				raise($urandom % (p + 1), 1'b1);
				wait_mode(2'b01);
				chk({mode, cpu_en}, 32'h0000_0002);
				count_ticks(32);
				chk(c, exp_ticks(div, 32));
			end
			if (s == 1)
				pulse_wdt();
			else if (s != 3)
				raise(p + 1 + $urandom % (7 - p), 1'b1);
			else
			begin
				raise(p + 1 + $urandom % (7 - p), 1'b1);
				c = 0;
				while (mode === 2'b11 && c < 2000)
				begin
					c++;
					@(posedge clk_in) #1;
				end
				chk(c, `PMC_OSC_START_CYC);
			end
			wait_mode(2'b00);
			chk({mode, cpu_en, fail_safe_clock_monitor}, 32'h0000_0003);
		end
		end_of_test();
	end
endmodule
